// ---- logic/flash_cmd_pkg.sv ----
// constants, command table and carriers for the serial flash instruction decoder
// assumes one 40 MHz system clock; serial pins arrive asynchronously
package flash_cmd_pkg;

    localparam int            SYNC_DEPTH  = 3;          // pin synchroniser length
    localparam logic [2:0]    BIT_LAST    = 3'h7;       // last bit of a byte
    localparam logic [1:0]    ADDR_BYTES  = 2'h3;       // address length in bytes
    localparam logic [8:0]    NO_LIMIT    = 9'h000;     // byte count unbounded
    localparam logic [8:0]    ID_LONG     = 9'h014;     // 20 identity bytes
    localparam logic [8:0]    ID_SHORT    = 9'h003;
    localparam logic [8:0]    ONE_BYTE    = 9'h001;
    localparam logic [8:0]    OTP_MAX     = 9'h041;     // 65 bytes
    localparam logic [8:0]    PAGE_MAX    = 9'h100;     // 256 bytes
    localparam logic [23:0]   ADDR_RESET  = 24'h000000;
    localparam logic [7:0]    BYTE_RESET  = 8'h00;

    typedef enum logic [4:0] {
        unknown_cmd, arm_write_latch_cmd, disarm_write_latch_cmd, fetch_identity,
        fetch_identity_short, fetch_state_reg, store_state_reg, store_lock_reg,
        fetch_lock_reg, plain_fetch, quick_fetch, two_line_quick_fetch,
        fetch_onetime_area, burn_onetime_area, page_write_cmd, two_line_page_write,
        block4k_wipe, block64k_wipe, whole_array_wipe, deep_sleep_cmd, wake_from_sleep_cmd
    } cmd_kind_t;

    // frame shape and policy of one opcode
    typedef struct packed {
        cmd_kind_t  kind;
        logic [1:0] addr_bytes;
        logic       dummy;
        logic       output_phase;
        logic       boundary;     // must end on a byte boundary
        logic       needs_latch;  // refused while latch clear, clears it when done
        logic [8:0] max_bytes;    // data bytes, 0 = none or unbounded
    } op_info_t;

    // decoded command handed to the core
    typedef struct packed {
        cmd_kind_t   kind;
        logic [23:0] addr;
        logic [7:0]  sector;
        logic [3:0]  subsector;
    } cmd_t;

    function automatic op_info_t decode_op(input logic [7:0] op);
        op_info_t i;
        i = '{unknown_cmd, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, NO_LIMIT};
        case (op)
            8'h06: i = '{arm_write_latch_cmd, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, NO_LIMIT};
            8'h04: i = '{disarm_write_latch_cmd, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, NO_LIMIT};
            8'h9F: i = '{fetch_identity, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, ID_LONG};
            8'h9E: i = '{fetch_identity_short, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, ID_SHORT};
            8'h05: i = '{fetch_state_reg, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, NO_LIMIT};
            8'h01: i = '{store_state_reg, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, ONE_BYTE};
            8'hE5: i = '{store_lock_reg, ADDR_BYTES, 1'b0, 1'b0, 1'b1, 1'b1, ONE_BYTE};
            8'hE8: i = '{fetch_lock_reg, ADDR_BYTES, 1'b0, 1'b1, 1'b0, 1'b0, ONE_BYTE};
            8'h03: i = '{plain_fetch, ADDR_BYTES, 1'b0, 1'b1, 1'b0, 1'b0, NO_LIMIT};
            8'h0B: i = '{quick_fetch, ADDR_BYTES, 1'b1, 1'b1, 1'b0, 1'b0, NO_LIMIT};
            8'h3B: i = '{two_line_quick_fetch, ADDR_BYTES, 1'b1, 1'b1, 1'b0, 1'b0, NO_LIMIT};
            8'h4B: i = '{fetch_onetime_area, ADDR_BYTES, 1'b1, 1'b1, 1'b0, 1'b0, OTP_MAX};
            8'h42: i = '{burn_onetime_area, ADDR_BYTES, 1'b0, 1'b0, 1'b1, 1'b1, OTP_MAX};
            8'h02: i = '{page_write_cmd, ADDR_BYTES, 1'b0, 1'b0, 1'b1, 1'b1, PAGE_MAX};
            8'hA2: i = '{two_line_page_write, ADDR_BYTES, 1'b0, 1'b0, 1'b1, 1'b1, PAGE_MAX};
            8'h20: i = '{block4k_wipe, ADDR_BYTES, 1'b0, 1'b0, 1'b1, 1'b1, NO_LIMIT};
            8'hD8: i = '{block64k_wipe, ADDR_BYTES, 1'b0, 1'b0, 1'b1, 1'b1, NO_LIMIT};
            8'hC7: i = '{whole_array_wipe, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, NO_LIMIT};
            8'hB9: i = '{deep_sleep_cmd, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, NO_LIMIT};
            8'hAB: i = '{wake_from_sleep_cmd, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, NO_LIMIT};
            default: i = '{unknown_cmd, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, NO_LIMIT};
        endcase
        return i;
    endfunction : decode_op

    // frame phases, one-hot
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_OPCODE = 7'b0000010,
        ST_ADDR   = 7'b0000100,
        ST_DUMMY  = 7'b0001000,
        ST_DIN    = 7'b0010000,
        ST_DOUT   = 7'b0100000,
        ST_IGNORE = 7'b1000000
    } phase_t;

endpackage : flash_cmd_pkg

// ---- logic/flash_instr_decoder.sv ----
// serial flash instruction decoder: samples the serial pins, frames opcodes,
// addresses and data, hands commands to the core and shifts read data out.
// assumes the core gives core_rd_byte within two clocks of cmd_go_reg or
// out_byte_req_reg, and raises core_busy for its whole write/erase cycle.
//
// Contract
// R1: all bytes move most significant bit first
// R2: input bits latched on rising clock edges
// R3: host opens each frame with opcode byte
// R4: frame shape follows the opcode table
// R5: read-type commands get output phase, any-bit end
// R6: write-type commands need byte-aligned deselect
// R7: array access ignored during internal busy cycle
// R8: 06h sets, 04h clears write latch
// R9: status and identity opcodes, no address
// R10: lock write/read with address and data
// R11: plain, fast and dual fast reads
// R12: one-time area read and write
// R13: page program and dual page program
// R14: 4K, 64K and whole-array erase
// R15: deep sleep entry and release
// R16: host arms latch before any write
// R17: output bits driven on falling edges
// R18: latch cleared at reset and write completion
// R19: address splits into sector and subsector
// R20: unknown opcodes ignored, output quiet
`timescale 1ns/1ps
module flash_instr_decoder
    import flash_cmd_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       select_n,
    input  wire logic       sclk,
    input  wire logic       serial_in_line,
    input  wire logic       core_busy,
    input  wire logic [7:0] core_rd_byte,
    output cmd_t            cmd_reg,
    output logic            cmd_go_reg,
    output logic [7:0]      in_byte_reg,
    output logic            in_byte_stb_reg,
    output logic            out_byte_req_reg,
    output logic            serial_out_line_reg,
    output logic            serial_out_oe_reg,
    output logic            write_arm_latch_reg
);

    // three-stage synchronisers; only the filtered level is used downstream
    logic [SYNC_DEPTH-1:0] sel_sync_reg, clk_sync_reg, din_sync_reg;
    logic                  sel_f_reg, clk_f_reg, din_f_reg, clk_prev_reg, sel_prev_reg;
    logic                  sel_f_next, clk_f_next, din_f_next;

    // a change counts once stages two and three agree
    always_comb begin
        sel_f_next = (sel_sync_reg[1] == sel_sync_reg[2]) ? sel_sync_reg[2] : sel_f_reg;
        clk_f_next = (clk_sync_reg[1] == clk_sync_reg[2]) ? clk_sync_reg[2] : clk_f_reg;
        din_f_next = (din_sync_reg[1] == din_sync_reg[2]) ? din_sync_reg[2] : din_f_reg;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sel_sync_reg <= '1;
            clk_sync_reg <= '0;
            din_sync_reg <= '0;
            sel_f_reg    <= 1'b1;
            clk_f_reg    <= 1'b0;
            din_f_reg    <= 1'b0;
            clk_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b1;
        end else begin
            sel_sync_reg <= {sel_sync_reg[1:0], select_n};
            clk_sync_reg <= {clk_sync_reg[1:0], sclk};
            din_sync_reg <= {din_sync_reg[1:0], serial_in_line};
            sel_f_reg    <= sel_f_next;
            clk_f_reg    <= clk_f_next;
            din_f_reg    <= din_f_next;
            clk_prev_reg <= clk_f_reg;
            sel_prev_reg <= sel_f_reg;
        end
    end

    logic sclk_rise, sclk_fall, deselect, selected;
    assign sclk_rise = clk_f_reg & ~clk_prev_reg;
    assign sclk_fall = ~clk_f_reg & clk_prev_reg;
    assign deselect  = sel_f_reg & ~sel_prev_reg;
    assign selected  = ~sel_f_reg;

    phase_t      state_reg, state_next;
    op_info_t    info_reg, info_next, op_info;
    logic [2:0]  bit_cnt_reg, bit_cnt_next, out_bit_reg, out_bit_next;
    logic [8:0]  byte_cnt_reg, byte_cnt_next, out_cnt_reg, out_cnt_next;
    logic [7:0]  shift_reg, shift_next, tx_reg, tx_next, rx_byte;
    logic [23:0] addr_reg, addr_next;
    logic        extra_reg, extra_next, sleeping_reg, sleeping_next;
    cmd_t        cmd_next;
    logic        go_next, stb_next, req_next, line_next, oe_next, latch_next;
    logic [7:0]  in_byte_next;
    logic        frame_ok, may_run;

    assign rx_byte = {shift_reg[6:0], din_f_reg}; // R1
    assign op_info = decode_op(rx_byte);

    // a write-type frame is whole when its data count fits the opcode
    assign frame_ok = (state_reg == ST_DIN) && (bit_cnt_reg == 3'h0) // R6
                   && ((info_reg.max_bytes == NO_LIMIT) ? !extra_reg : byte_cnt_reg != 9'h000);
    assign may_run  = frame_ok && !core_busy // R7
                   && (!info_reg.needs_latch || write_arm_latch_reg); // R16

    // frame sequencer, serial shifters and command hand-off
    always_comb begin
        state_next    = state_reg;
        info_next     = info_reg;
        bit_cnt_next  = bit_cnt_reg;
        byte_cnt_next = byte_cnt_reg;
        out_bit_next  = out_bit_reg;
        out_cnt_next  = out_cnt_reg;
        shift_next    = shift_reg;
        tx_next       = tx_reg;
        addr_next     = addr_reg;
        extra_next    = extra_reg;
        sleeping_next = sleeping_reg;
        latch_next    = write_arm_latch_reg;
        cmd_next      = cmd_reg;
        go_next       = 1'b0;
        stb_next      = 1'b0;
        req_next      = 1'b0;
        in_byte_next  = in_byte_reg;
        line_next     = serial_out_line_reg;
        oe_next       = serial_out_oe_reg;
        cmd_next.sector    = addr_reg[23:16]; // R19
        cmd_next.subsector = addr_reg[15:12]; // R19
        cmd_next.addr      = addr_reg;
        if (deselect) begin
            // boundary commands are decided only at the closing edge of select; reads start at the output phase
            if (info_reg.boundary && may_run) begin // R6
                go_next       = 1'b1;
                cmd_next.kind = info_reg.kind;
                case (info_reg.kind)
                    arm_write_latch_cmd: latch_next    = 1'b1; // R8
                    deep_sleep_cmd:      sleeping_next = 1'b1; // R15
                    default:             latch_next    = 1'b0; // R8 R18
                endcase
            end
            state_next = ST_IDLE;
            oe_next    = 1'b0; // R5
        end else if (state_reg == ST_IDLE) begin
            if (selected) begin
                state_next    = ST_OPCODE; // R3
                bit_cnt_next  = 3'h0;
                byte_cnt_next = 9'h000;
                out_bit_next  = 3'h0;
                out_cnt_next  = 9'h000;
                extra_next    = 1'b0;
            end
        end else if (sclk_rise) begin
            bit_cnt_next = bit_cnt_reg + 3'h1; // R2
            shift_next   = rx_byte;
            if (bit_cnt_reg == BIT_LAST) begin
                byte_cnt_next = byte_cnt_reg + 9'h001;
                case (state_reg)
                    ST_OPCODE: begin
                        info_next     = op_info;
                        byte_cnt_next = 9'h000;
                        // sleep answers only wake; busy lets only status through
                        if (op_info.kind == unknown_cmd) begin
                            state_next = ST_IGNORE; // R20
                        end else if (sleeping_reg && op_info.kind != wake_from_sleep_cmd) begin
                            state_next = ST_IGNORE; // R15
                        end else if (core_busy && op_info.kind != fetch_state_reg) begin
                            state_next = ST_IGNORE; // R7
                        end else if (op_info.addr_bytes != 2'h0) begin
                            state_next = ST_ADDR; // R4
                        end else if (op_info.output_phase) begin
                            state_next    = ST_DOUT; // R5 R9
                            go_next       = 1'b1;
                            cmd_next.kind = op_info.kind;
                            if (op_info.kind == wake_from_sleep_cmd) begin
                                sleeping_next = 1'b0; // R15
                            end
                        end else begin
                            state_next = ST_DIN; // R4
                        end
                    end
                    ST_ADDR: begin
                        addr_next = {addr_reg[15:0], rx_byte}; // R1 R10 R11
                        if (byte_cnt_reg[1:0] == info_reg.addr_bytes - 2'h1) begin
                            byte_cnt_next = 9'h000;
                            if (info_reg.dummy) begin
                                state_next = ST_DUMMY; // R11 R12
                            end else if (info_reg.output_phase) begin
                                state_next    = ST_DOUT;
                                go_next       = 1'b1;
                                cmd_next.kind = info_reg.kind;
                                cmd_next.addr = {addr_reg[15:0], rx_byte};
                                cmd_next.sector    = addr_reg[15:8];
                                cmd_next.subsector = addr_reg[7:4];
                            end else begin
                                state_next = ST_DIN; // R13 R14
                            end
                        end
                    end
                    ST_DUMMY: begin
                        state_next    = ST_DOUT; // R11
                        go_next       = 1'b1;
                        cmd_next.kind = info_reg.kind;
                    end
                    ST_DIN: begin
                        // bytes past the limit are dropped, not wrapped
                        if (info_reg.max_bytes == NO_LIMIT) begin
                            extra_next    = 1'b1;
                            byte_cnt_next = byte_cnt_reg;
                        end else if (byte_cnt_reg != info_reg.max_bytes) begin
                            stb_next     = 1'b1; // R12 R13
                            in_byte_next = rx_byte;
                        end else begin
                            byte_cnt_next = byte_cnt_reg;
                        end
                    end
                    default: byte_cnt_next = byte_cnt_reg;
                endcase
            end
        end else if (sclk_fall && state_reg == ST_DOUT) begin
            out_bit_next = out_bit_reg + 3'h1;
            if (out_bit_reg == 3'h0) begin
                if (info_reg.max_bytes != NO_LIMIT && out_cnt_reg == info_reg.max_bytes) begin
                    oe_next      = 1'b0; // R9
                    out_bit_next = 3'h0;
                end else begin
                    line_next    = core_rd_byte[7]; // R1 R17
                    tx_next      = {core_rd_byte[6:0], 1'b0};
                    oe_next      = 1'b1;
                    req_next     = 1'b1;
                    out_cnt_next = out_cnt_reg + 9'h001;
                end
            end else begin
                line_next = tx_reg[7]; // R17
                tx_next   = {tx_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg           <= ST_IDLE;
            info_reg            <= '0;
            bit_cnt_reg         <= 3'h0;
            byte_cnt_reg        <= 9'h000;
            out_bit_reg         <= 3'h0;
            out_cnt_reg         <= 9'h000;
            shift_reg           <= BYTE_RESET;
            tx_reg              <= BYTE_RESET;
            addr_reg            <= ADDR_RESET;
            extra_reg           <= 1'b0;
            sleeping_reg        <= 1'b0;
            write_arm_latch_reg <= 1'b0; // R18
            cmd_reg             <= '0;
            cmd_go_reg          <= 1'b0;
            in_byte_stb_reg     <= 1'b0;
            in_byte_reg         <= BYTE_RESET;
            out_byte_req_reg    <= 1'b0;
            serial_out_line_reg <= 1'b0;
            serial_out_oe_reg   <= 1'b0;
        end else begin
            state_reg           <= state_next;
            info_reg            <= info_next;
            bit_cnt_reg         <= bit_cnt_next;
            byte_cnt_reg        <= byte_cnt_next;
            out_bit_reg         <= out_bit_next;
            out_cnt_reg         <= out_cnt_next;
            shift_reg           <= shift_next;
            tx_reg              <= tx_next;
            addr_reg            <= addr_next;
            extra_reg           <= extra_next;
            sleeping_reg        <= sleeping_next;
            write_arm_latch_reg <= latch_next;
            cmd_reg             <= cmd_next;
            cmd_go_reg          <= go_next;
            in_byte_stb_reg     <= stb_next;
            in_byte_reg         <= in_byte_next;
            out_byte_req_reg    <= req_next;
            serial_out_line_reg <= line_next;
            serial_out_oe_reg   <= oe_next;
        end
    end

    // checks on the decoder's own outputs
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_quiet_unless_out: assert property (serial_out_oe_reg |-> state_reg == ST_DOUT) // R20
        else $error("output enabled outside output phase");
    a_write_aligned: assert property (cmd_go_reg && $past(info_reg.boundary) && $past(deselect)
        |-> $past(bit_cnt_reg) == 3'h0) // R6
        else $error("write command ran off a byte boundary");
    a_arm_sets_latch: assert property (cmd_go_reg && cmd_reg.kind == arm_write_latch_cmd
        |-> write_arm_latch_reg) // R8
        else $error("arm did not set latch");
    a_write_clears: assert property (cmd_go_reg && $past(info_reg.needs_latch) && $past(deselect)
        |-> $past(write_arm_latch_reg) && !write_arm_latch_reg) // R16
        else $error("write ran without latch or left it set");
    a_busy_blocks: assert property (cmd_go_reg && cmd_reg.kind != fetch_state_reg
        |-> !$past(core_busy)) // R7
        else $error("command ran while core busy");
    a_out_msb_first: assert property (sclk_fall && state_reg == ST_DOUT && out_bit_reg == 3'h0
        && req_next |=> serial_out_line_reg == $past(core_rd_byte[7])) // R17
        else $error("first output bit not the msb");
    a_deselect_idle: assert property (deselect |=> state_reg == ST_IDLE && !serial_out_oe_reg) // R5
        else $error("deselect did not end the frame");
    a_sector_split: assert property (cmd_go_reg |-> cmd_reg.sector == cmd_reg.addr[23:16]
        && cmd_reg.subsector == cmd_reg.addr[15:12]) // R19
        else $error("sector fields disagree with address");
    a_opcode_first: assert property ($rose(selected) |=> state_reg == ST_OPCODE) // R3
        else $error("frame did not open with opcode phase");

    c_page_write: cover property (cmd_go_reg && cmd_reg.kind == page_write_cmd);
    c_fast_read:  cover property (out_byte_req_reg && info_reg.kind == quick_fetch);
    c_rejected:   cover property (deselect && info_reg.boundary && !may_run);
    c_unknown:    cover property (state_reg == ST_IGNORE);

endmodule : flash_instr_decoder

// ---- test/serial_flash_instruction_decoder_tb_top.sv ----
// self-checking bench for the serial flash instruction decoder
// assumes the host model drives the serial pins and the bench plays the core
`timescale 1ns/1ps
module serial_flash_instruction_decoder_tb_top import flash_cmd_pkg::*;;
    typedef struct packed {
        logic [7:0] op;
        cmd_kind_t  kind;
        logic [4:0] f; // address, dummy, needs latch, data (1 in, 2 out)
    } row_t;
    row_t        tbl[20] = '{'{8'h06, arm_write_latch_cmd, 5'h00},
        '{8'h04, disarm_write_latch_cmd, 5'h00}, '{8'h9F, fetch_identity, 5'h02},
        '{8'h9E, fetch_identity_short, 5'h02}, '{8'h05, fetch_state_reg, 5'h02},
        '{8'h01, store_state_reg, 5'h05}, '{8'hE5, store_lock_reg, 5'h15},
        '{8'hE8, fetch_lock_reg, 5'h12}, '{8'h03, plain_fetch, 5'h12},
        '{8'h0B, quick_fetch, 5'h1A}, '{8'h3B, two_line_quick_fetch, 5'h1A},
        '{8'h4B, fetch_onetime_area, 5'h1A}, '{8'h42, burn_onetime_area, 5'h15},
        '{8'h02, page_write_cmd, 5'h15}, '{8'hA2, two_line_page_write, 5'h15},
        '{8'h20, block4k_wipe, 5'h14}, '{8'hD8, block64k_wipe, 5'h14},
        '{8'hC7, whole_array_wipe, 5'h04}, '{8'hB9, deep_sleep_cmd, 5'h00},
        '{8'hAB, wake_from_sleep_cmd, 5'h02}};
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        core_busy = 1'b0;
    logic [7:0]  rd_base = 8'h00;
    logic [7:0]  rd_cnt = 8'h00;
    logic [7:0]  core_rd_byte;
    logic        select_n, sclk, serial_in_line, cmd_go_reg, in_byte_stb_reg;
    logic        out_byte_req_reg, serial_out_line_reg, serial_out_oe_reg;
    logic        write_arm_latch_reg;
    logic [7:0]  in_byte_reg;
    cmd_t        cmd_reg, exp_c;
    int          error_cnt = 0;
    int          compares = 0;
    int          oe_hits = 0;
    logic [31:0] seed = 32'h8451D2DF;
    cmd_t        cmd_q[$];
    logic        adr_q[$];
    logic [7:0]  byte_q[$];

    always #12.5 clock = ~clock;

    flash_instr_decoder u_dut (.clock(clock), .reset_n(reset_n), .select_n(select_n),
        .sclk(sclk), .serial_in_line(serial_in_line), .core_busy(core_busy),
        .core_rd_byte(core_rd_byte), .cmd_reg(cmd_reg), .cmd_go_reg(cmd_go_reg),
        .in_byte_reg(in_byte_reg), .in_byte_stb_reg(in_byte_stb_reg),
        .out_byte_req_reg(out_byte_req_reg), .serial_out_line_reg(serial_out_line_reg),
        .serial_out_oe_reg(serial_out_oe_reg), .write_arm_latch_reg(write_arm_latch_reg));
    spi_host_model u_host (.select_n(select_n), .sclk(sclk), .mosi(serial_in_line),
        .miso(serial_out_line_reg));

    // core stand-in: next byte one clock after each request
    assign core_rd_byte = rd_base + rd_cnt;
    always @(posedge clock) rd_cnt <= select_n ? 8'h00 : rd_cnt + {7'h00, out_byte_req_reg};

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // one frame: opcode, address, dummy, data, reads, stray bits
    task automatic run(input row_t t, input logic [23:0] a, input int nrd, input int xb,
                       input logic acc);
        logic [7:0] r;
        @(posedge clock);
        #2;
        seed = lfsr(seed);
        rd_base = seed[7:0];
        u_host.half = seed[8] ? 300 : 100; // slow host half the time
        if (acc) begin
            cmd_q.push_back(cmd_t'{t.kind, a, a[23:16], a[15:12]});
            adr_q.push_back(t.f[4]);
        end
        u_host.begin_frame();
        u_host.shift(t.op, 8, r);
        if (t.f[4]) for (int i = 2; i >= 0; i--) u_host.shift(a[8*i+:8], 8, r);
        if (t.f[3]) u_host.shift(seed[23:16], 8, r);
        if (t.f[1:0] == 2'h1 && acc) byte_q.push_back(seed[31:24]);
        if (t.f[1:0] == 2'h1) u_host.shift(seed[31:24], 8, r);
        for (int k = 0; k < nrd; k++) begin
            u_host.shift(seed[15:8], 8, r);
            chk("read byte", 24'(8'(rd_base + k)), 24'(r));
            chk("output enable", 24'h1, 24'(serial_out_oe_reg));
        end
        if (xb > 0) u_host.shift(8'hA5, xb, r);
        u_host.end_frame();
        chk("pending commands", 24'h0, 24'(cmd_q.size() + byte_q.size()));
    endtask : run

    // result watcher: oldest note against each pulse
    always @(posedge clock) begin
        if (serial_out_oe_reg === 1'b1) oe_hits++;
        if (in_byte_stb_reg === 1'b1 && byte_q.size() == 0) chk("data strobe", 0, 1);
        else if (in_byte_stb_reg === 1'b1) chk("data", byte_q.pop_front(), in_byte_reg);
        if (cmd_go_reg === 1'b1 && cmd_q.size() == 0) chk("command", 0, 1);
        else if (cmd_go_reg === 1'b1) begin
            exp_c = cmd_q.pop_front();
            chk("kind", 24'(exp_c.kind), 24'(cmd_reg.kind));
            if (adr_q.pop_front()) begin
                chk("address", exp_c.addr, cmd_reg.addr);
                chk("sector", 24'(exp_c.sector), 24'(cmd_reg.sector));
                chk("subsector", 24'(exp_c.subsector), 24'(cmd_reg.subsector));
            end
        end
    end

    // main sequence: whole opcode table, long read, refusals
    initial begin
        repeat (10) @(posedge clock);
        #2 reset_n = 1'b1;
        repeat (5) @(posedge clock);
        foreach (tbl[i]) begin
            seed = lfsr(seed);
            if (tbl[i].f[2]) run(tbl[0], 24'h0, 0, 0, 1'b1);
            run(tbl[i], seed[23:0], int'(tbl[i].f[1]), 0, 1'b1);
            chk("latch", 24'(tbl[i].kind == arm_write_latch_cmd), 24'(write_arm_latch_reg));
        end
        run(tbl[8], 24'h1FF7AB, 4, 0, 1'b1);
        run(tbl[0], 24'h0, 0, 3, 1'b0);
        chk("latch", 24'h0, 24'(write_arm_latch_reg));
        oe_hits = 0;
        run(row_t'{8'hFF, unknown_cmd, 5'h00}, 24'h0, 0, 8, 1'b0);
        chk("output enable", 24'h0, 24'(oe_hits));
        run(tbl[0], 24'h0, 0, 0, 1'b1);
        core_busy = 1'b1;
        // latch armed, so only the busy core can refuse this write
        run(tbl[13], seed[23:0], 0, 0, 1'b0);
        chk("latch", 24'h1, 24'(write_arm_latch_reg));
        run(tbl[8], seed[23:0], 0, 8, 1'b0);
        run(tbl[4], 24'h0, 2, 0, 1'b1);
        core_busy = 1'b0;
        print_verdict();
    end

    // watchdog well beyond the expected run of about 0.2 to 0.55 milliseconds
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
endmodule : serial_flash_instruction_decoder_tb_top

// ---- test/spi_host_model.sv ----
// spi host model: drives select, clock and data in mode 0, msb first
// assumes the decoder samples its pins with a system clock of >=8x sclk
`timescale 1ns/1ps
module spi_host_model (
    output logic      select_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    int half = 100; // sclk half period in ns, raised to act as a slow host

    // idle pins: deselected, clock parked low
    initial begin
        select_n = 1'b1;
        sclk     = 1'b0;
        mosi     = 1'b0;
    end

    // n bits msb first; reply taken late in the high phase, where it has settled
    task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            mosi = b[i];
            #(half) sclk = 1'b1;
            #(half - 5) r[i] = miso;
            #5 sclk = 1'b0;
        end
    endtask : shift

    // select falls with sclk low
    task automatic begin_frame;
        select_n = 1'b0;
        #(half);
    endtask : begin_frame

    // select rises with sclk low, then a gap for the decision to land
    task automatic end_frame;
        #(half) select_n = 1'b1;
        mosi = ~mosi; // released line shows the inverse, never a stale bit
        #600;
    endtask : end_frame
endmodule : spi_host_model
